// ### include/lfwt_pkg.sv
// lfwt_pkg: constants, timing tables and state type for the wake timer block
// assumes a 25 MHz system clock and a 32 kHz oscillator tick derived from it
package lfwt_pkg;

    // clock rates
    localparam int SYS_HZ       = 25_000_000;
    localparam int OSC_HZ       = 32_000;
    localparam int DIV_CYCLES   = SYS_HZ / OSC_HZ;
    localparam int TICKS_PER_MS = OSC_HZ / 1000;

    // counter width in oscillator ticks
    localparam int CNT_W = 11;

    // timeouts, printed figure and tick count
    localparam int IDLE_MS      = 16;
    localparam int NOISE_MS     = 32;
    localparam int SETTLE_US    = 3500;
    localparam int IDLE_TICKS   = IDLE_MS * TICKS_PER_MS;
    localparam int NOISE_TICKS  = NOISE_MS * TICKS_PER_MS;
    localparam int SETTLE_TICKS = 115;

    localparam logic [CNT_W-1:0] IDLE_LAST   = CNT_W'(IDLE_TICKS - 1);
    localparam logic [CNT_W-1:0] NOISE_LAST  = CNT_W'(NOISE_TICKS - 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_TICKS - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO    = {CNT_W{1'b0}};
    localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);

    // header select codes
    localparam logic [1:0] SEL_00 = 2'h0;
    localparam logic [1:0] SEL_01 = 2'h1;
    localparam logic [1:0] SEL_10 = 2'h2;
    localparam logic [1:0] SEL_11 = 2'h3;

    localparam int CHANNELS = 3;

    typedef enum logic [2:0] {
        LFWT_STANDBY,
        LFWT_SETTLE,
        LFWT_HDR_WAIT,
        LFWT_HDR_HIGH,
        LFWT_HDR_LOW,
        LFWT_PASS,
        LFWT_FAIL
    } lfwt_state_t;

    function automatic logic [CNT_W-1:0] ms_ticks(input int ms);
        ms_ticks = CNT_W'(ms * TICKS_PER_MS);
    endfunction

    // minimum header high time
    function automatic logic [CNT_W-1:0] high_ticks(input logic [1:0] hsel);
        unique case (hsel)
            SEL_00:  high_ticks = ms_ticks(1);
            SEL_01:  high_ticks = ms_ticks(2);
            default: high_ticks = ms_ticks(4);
        endcase
    endfunction

    // minimum header low time
    function automatic logic [CNT_W-1:0] low_ticks(input logic [1:0] lsel);
        unique case (lsel)
            SEL_10:  low_ticks = ms_ticks(2);
            SEL_11:  low_ticks = ms_ticks(4);
            default: low_ticks = ms_ticks(1);
        endcase
    endfunction

    // maximum header period
    function automatic logic [CNT_W-1:0] period_ticks(input logic [1:0] hsel,
                                                      input logic [1:0] lsel);
        logic [1:0] h;
        h = (hsel == SEL_11) ? SEL_10 : hsel;
        unique case ({h, lsel})
            {SEL_00, SEL_10}: period_ticks = ms_ticks(4);
            {SEL_00, SEL_11}: period_ticks = ms_ticks(6);
            {SEL_01, SEL_10}: period_ticks = ms_ticks(5);
            {SEL_01, SEL_11}: period_ticks = ms_ticks(8);
            {SEL_10, SEL_10}: period_ticks = ms_ticks(8);
            {SEL_10, SEL_11}: period_ticks = ms_ticks(10);
            {SEL_01, SEL_00},
            {SEL_01, SEL_01}: period_ticks = ms_ticks(4);
            {SEL_10, SEL_00},
            {SEL_10, SEL_01}: period_ticks = ms_ticks(6);
            default:          period_ticks = ms_ticks(3);
        endcase
    endfunction

endpackage

// ### include/lfwt_tick_if.sv
// lfwt_tick_if: oscillator run request and tick enable between top and divider
// assumes both ends sit on clk_sys
`timescale 1ns/1ns
`default_nettype none
interface lfwt_tick_if;
    logic run;
    logic tick;

    modport gen  (input run, output tick);
    modport user (output run, input tick);
endinterface
`default_nettype wire

// ### hdl/lfwt_tick_gen.sv
// lfwt_tick_gen: divides clk_sys down to a one-cycle 32 kHz tick enable
// assumes run is low while the oscillator is powered down
`timescale 1ns/1ns
`default_nettype none
module lfwt_tick_gen #(
    parameter int DIV = lfwt_pkg::DIV_CYCLES
) (
    // clock and reset
    input  wire logic   clk_sys,
    input  wire logic   reset_n,
    // tick link
    lfwt_tick_if.gen    tk
);
    localparam int DW = $clog2(DIV);
    localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);

    logic [DW-1:0] div_q;
    logic [DW-1:0] div_d;
    logic          tick_q;
    logic          tick_d;

    // divider stops and clears while oscillator is off
    always_comb begin
        div_d  = div_q;
        tick_d = 1'b0;
        if (!tk.run) begin
            div_d = '0;
        end else if (div_q == DIV_LAST) begin
            div_d  = '0;
            tick_d = 1'b1;
        end else begin
            div_d = div_q + DW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
        end
    end

    assign tk.tick = tick_q;
endmodule
`default_nettype wire

// ### hdl/lfwt_top.sv
// lfwt_top: idle, noise and gain-settle timers plus header filter gating data out
// assumes all inputs synchronous to clk_sys; rx_in is the OR of channel demod outputs
`timescale 1ns/1ns
`default_nettype none
module lfwt_top #(
    parameter int CH  = lfwt_pkg::CHANNELS,
    parameter int DIV = lfwt_pkg::DIV_CYCLES
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          reset_n,
    // receiver inputs
    input  wire logic          rx_in,
    input  wire logic [CH-1:0] chan_sig,
    // microcontroller side
    input  wire logic          cs_n,
    input  wire logic [CH-1:0] chan_en,
    input  wire logic          filter_en,
    input  wire logic [1:0]    high_time_select,
    input  wire logic [1:0]    low_time_select,
    // outputs
    output logic               demod_data_out,
    output logic               alert_n,
    output logic               noise_timeout_flag,
    output logic [CH-1:0]      wake_chan,
    output logic               soft_reset,
    output logic               standby,
    output logic               osc_run
);
    localparam int W = lfwt_pkg::CNT_W;

    lfwt_tick_if tk ();

    lfwt_tick_gen #(
        .DIV (DIV)
    ) u_tick (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .tk      (tk.gen)
    );

    lfwt_pkg::lfwt_state_t st_q;
    lfwt_pkg::lfwt_state_t st_d;
    logic [W-1:0]          tmr_q;
    logic [W-1:0]          tmr_d;
    logic [W-1:0]          idle_q;
    logic [W-1:0]          idle_d;
    logic [W-1:0]          noise_q;
    logic [W-1:0]          noise_d;
    logic                  rx_q;
    logic                  alarm_q;
    logic                  alarm_d;
    logic [CH-1:0]         wake_q;
    logic [CH-1:0]         wake_d;
    logic                  data_q;
    logic                  data_d;
    logic                  soft_q;
    logic                  soft_d;

    logic                  tick;
    logic                  rise;
    logic                  fall;
    logic                  idle_on;
    logic                  noise_on;
    logic [W-1:0]          hi_min;
    logic [W-1:0]          lo_min;
    logic [W-1:0]          per_max;

    assign tick    = tk.tick;
    assign tk.run  = (st_q != lfwt_pkg::LFWT_STANDBY);
    assign rise    = rx_in & ~rx_q;
    assign fall    = ~rx_in & rx_q;
    assign hi_min  = lfwt_pkg::high_ticks(high_time_select);
    assign lo_min  = lfwt_pkg::low_ticks(low_time_select);
    assign per_max = lfwt_pkg::period_ticks(high_time_select, low_time_select);
    assign idle_on = (st_q != lfwt_pkg::LFWT_STANDBY)
                   && (st_q != lfwt_pkg::LFWT_SETTLE);
    assign noise_on = filter_en && idle_on
                    && (st_q != lfwt_pkg::LFWT_PASS);

    // header filter, timers and status
    always_comb begin
        st_d    = st_q;
        tmr_d   = tmr_q;
        idle_d  = idle_q;
        noise_d = noise_q;
        alarm_d = alarm_q;
        wake_d  = wake_q;
        soft_d  = 1'b0;

        unique case (st_q)
            lfwt_pkg::LFWT_STANDBY: begin
                if (rx_in) begin
                    st_d  = lfwt_pkg::LFWT_SETTLE;
                    tmr_d = lfwt_pkg::CNT_ZERO;
                end
            end
            lfwt_pkg::LFWT_SETTLE: begin
                if (tick) begin
                    tmr_d = tmr_q + lfwt_pkg::CNT_ONE;
                    if (tmr_q == lfwt_pkg::SETTLE_LAST) begin
                        tmr_d = lfwt_pkg::CNT_ZERO;
                        if (rx_in) begin
                            wake_d = chan_en & chan_sig;
                            st_d   = filter_en ? lfwt_pkg::LFWT_HDR_WAIT
                                               : lfwt_pkg::LFWT_PASS;
                        end else begin
                            soft_d = 1'b1;
                        end
                    end
                end
            end
            lfwt_pkg::LFWT_HDR_WAIT: begin
                if (rise) begin
                    st_d  = lfwt_pkg::LFWT_HDR_HIGH;
                    tmr_d = lfwt_pkg::CNT_ZERO;
                end else if (tick) begin
                    tmr_d = tmr_q + lfwt_pkg::CNT_ONE;
                    if (tmr_q == per_max) begin
                        st_d = lfwt_pkg::LFWT_FAIL;
                    end
                end
            end
            lfwt_pkg::LFWT_HDR_HIGH: begin
                if (fall) begin
                    tmr_d = lfwt_pkg::CNT_ZERO;
                    if (tmr_q >= hi_min && tmr_q <= per_max) begin
                        st_d = lfwt_pkg::LFWT_HDR_LOW;
                    end else begin
                        st_d = lfwt_pkg::LFWT_FAIL;
                    end
                end else if (tick) begin
                    tmr_d = tmr_q + lfwt_pkg::CNT_ONE;
                    if (tmr_q == per_max) begin
                        st_d = lfwt_pkg::LFWT_FAIL;
                    end
                end
            end
            lfwt_pkg::LFWT_HDR_LOW: begin
                if (rise) begin
                    tmr_d = lfwt_pkg::CNT_ZERO;
                    if (tmr_q >= lo_min && tmr_q <= per_max) begin
                        st_d = lfwt_pkg::LFWT_PASS;
                    end else begin
                        st_d = lfwt_pkg::LFWT_FAIL;
                    end
                end else if (tick) begin
                    tmr_d = tmr_q + lfwt_pkg::CNT_ONE;
                    if (tmr_q == per_max) begin
                        st_d = lfwt_pkg::LFWT_FAIL;
                    end
                end
            end
            lfwt_pkg::LFWT_PASS: begin
                st_d = lfwt_pkg::LFWT_PASS;
            end
            lfwt_pkg::LFWT_FAIL: begin
                st_d = lfwt_pkg::LFWT_FAIL;
            end
        endcase

        // idle timer
        if ((rx_in != rx_q) || !cs_n) begin
            idle_d = lfwt_pkg::CNT_ZERO;
        end else if (tick && idle_on) begin
            idle_d = idle_q + lfwt_pkg::CNT_ONE;
            if (idle_q == lfwt_pkg::IDLE_LAST) begin
                soft_d = 1'b1;
            end
        end

        // noise timer; chip select clear loses to a same-cycle expiry
        if (!cs_n) begin
            alarm_d = 1'b0;
        end
        if (tick && noise_on && noise_q == lfwt_pkg::NOISE_LAST) begin
            alarm_d = 1'b1;
            noise_d = lfwt_pkg::CNT_ZERO;
        end else if (!cs_n || !filter_en || st_q == lfwt_pkg::LFWT_PASS) begin
            noise_d = lfwt_pkg::CNT_ZERO;
        end else if (tick && noise_on) begin
            noise_d = noise_q + lfwt_pkg::CNT_ONE;
        end

        // soft reset returns state and timers to standby; alarm and wake bits hold
        if (soft_d) begin
            st_d    = lfwt_pkg::LFWT_STANDBY;
            tmr_d   = lfwt_pkg::CNT_ZERO;
            idle_d  = lfwt_pkg::CNT_ZERO;
            noise_d = lfwt_pkg::CNT_ZERO;
        end

        data_d = (st_d == lfwt_pkg::LFWT_PASS) && rx_in;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q    <= lfwt_pkg::LFWT_STANDBY;
            tmr_q   <= '0;
            idle_q  <= '0;
            noise_q <= '0;
            rx_q    <= 1'b0;
            alarm_q <= 1'b0;
            wake_q  <= '0;
            data_q  <= 1'b0;
            soft_q  <= 1'b0;
        end else begin
            st_q    <= st_d;
            tmr_q   <= tmr_d;
            idle_q  <= idle_d;
            noise_q <= noise_d;
            rx_q    <= rx_in;
            alarm_q <= alarm_d;
            wake_q  <= wake_d;
            data_q  <= data_d;
            soft_q  <= soft_d;
        end
    end

    // outputs
    assign demod_data_out     = data_q;
    assign alert_n            = ~alarm_q;
    assign noise_timeout_flag = alarm_q;
    assign wake_chan          = wake_q;
    assign soft_reset         = soft_q;
    assign standby            = (st_q == lfwt_pkg::LFWT_STANDBY);
    assign osc_run            = tk.run;
endmodule
`default_nettype wire

// ### dv/lfwt_checker_assertions.sv
// lfwt_checker: port-level timing checks for lfwt_top
// assumes the oscillator tick divider of the bound lfwt_top
`timescale 1ns/1ns
`default_nettype none
module lfwt_checker #(
    parameter int CH  = lfwt_pkg::CHANNELS,
    parameter int DIV = lfwt_pkg::DIV_CYCLES
) (
    // clock and reset
    input wire logic          clk_sys,
    input wire logic          reset_n,
    // inputs
    input wire logic          rx_in,
    input wire logic          cs_n,
    input wire logic          filter_en,
    // outputs
    input wire logic          demod_data_out,
    input wire logic          alert_n,
    input wire logic          noise_timeout_flag,
    input wire logic [CH-1:0] wake_chan,
    input wire logic          soft_reset,
    input wire logic          standby,
    input wire logic          osc_run
);
    localparam int TK     = DIV;
    localparam int SET_LO = 114 * TK;
    localparam int IDL_HI = 630 * TK;
    localparam int NOI_LO = 1137 * TK;
    int   run_q;
    int   run_d;
    int   idl_q;
    int   idl_d;
    logic rx_q;
    // cycles of oscillator run and of input quiet
    always_comb begin
        run_d = osc_run ? run_q + 1 : 0;
        idl_d = (!osc_run || !cs_n || rx_in != rx_q) ? 0 : idl_q + 1;
    end
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            run_q <= 0;
            idl_q <= 0;
            rx_q  <= 1'h0;
        end else begin
            run_q <= run_d;
            idl_q <= idl_d;
            rx_q  <= rx_in;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    flag_mirror_a: assert property (noise_timeout_flag != alert_n)
        else $error("flag not inverse of alert");
    osc_mirror_a: assert property (osc_run != standby)
        else $error("osc run vs standby");
    reset_pulse_a: assert property (soft_reset |=> !soft_reset)
        else $error("soft reset too long");
    reset_standby_a: assert property (soft_reset |-> ##[0:2] standby)
        else $error("no standby after soft reset");
    data_follow_a: assert property (demod_data_out |-> $past(rx_in))
        else $error("data without input");
    data_gate_a: assert property (demod_data_out |-> run_q >= SET_LO)
        else $error("data before settle");
    wake_late_a: assert property ($changed(wake_chan) |-> run_q >= SET_LO)
        else $error("wake bits early");
    idle_bound_a: assert property (idl_q <= IDL_HI)
        else $error("idle timeout missed");
    alert_late_a: assert property ($fell(alert_n) |-> run_q >= NOI_LO)
        else $error("alert early");
    alert_off_a:
        assert property ($fell(alert_n) |-> $past(filter_en) || $past(filter_en, 2))
        else $error("alert with filter off");
    alert_hold_a: assert property (!alert_n && cs_n |=> !alert_n)
        else $error("alert dropped");
    pass_c: cover property ($rose(demod_data_out));
    wake_c: cover property ($changed(wake_chan));
    cs_c: cover property (!cs_n && osc_run);
    alert_c: cover property ($fell(alert_n));
endmodule
bind lfwt_top lfwt_checker #(.CH(CH), .DIV(DIV)) u_chk (.clk_sys, .reset_n, .rx_in, .cs_n,
    .filter_en, .demod_data_out, .alert_n, .noise_timeout_flag, .wake_chan,
    .soft_reset, .standby, .osc_run);
`default_nettype wire

// ### dv/lfwt_mcu_model.sv
// lfwt_mcu_model: controlling microcontroller on config and alert pins
// assumes one write is framed by one chip-select low cycle
`timescale 1ns/1ns
`default_nettype none
module lfwt_mcu_model (
    // clock
    input wire logic   clk_sys,
    // from device
    input wire logic   alert_n,
    // to device
    output logic       cs_n,
    output logic [2:0] chan_en,
    output logic       filter_en,
    output logic [1:0] high_time_select,
    output logic [1:0] low_time_select
);
    initial begin
        cs_n             = 1'h1;
        chan_en          = 3'h0;
        filter_en        = 1'h0;
        high_time_select = 2'h0;
        low_time_select  = 2'h0;
    end
    // one write of channel and header settings
    task automatic cfg_write(input logic [2:0] en, input logic [1:0] hs, input logic [1:0] ls);
        @(posedge clk_sys);
        cs_n             <= 1'h0;
        chan_en          <= en;
        filter_en        <= 1'h1;
        high_time_select <= hs;
        low_time_select  <= ls;
        @(posedge clk_sys);
        cs_n <= 1'h1;
    endtask
    // back off: shut channels down on alert
    always @(posedge clk_sys) begin
        if (!alert_n) begin
            chan_en <= 3'h0;
        end
    end
endmodule
`default_nettype wire

// ### dv/tb_lfwt_top.sv
// tb_lfwt_top: reset, settle, header pass, idle timeout, settle abort, noise alert
// assumes lfwt_top built with a short tick divider to bound run time
`timescale 1ns/1ns
`default_nettype none
module tb_lfwt_top;
    localparam int TK = 20;
    logic        clk_sys = 1'h0;
    logic        reset_n = 1'h0;
    logic        rx_in = 1'h0;
    logic [2:0]  chan_sig = 3'h0;
    logic        cs_n;
    logic [2:0]  chan_en;
    logic        filter_en;
    logic [1:0]  high_time_select;
    logic [1:0]  low_time_select;
    logic        demod_data_out;
    logic        alert_n;
    logic        noise_timeout_flag;
    logic [2:0]  wake_chan;
    logic        soft_reset;
    logic        standby;
    logic        osc_run;
    logic [15:0] lfsr = 16'h0009;
    logic [2:0]  en;
    logic [2:0]  sg;
    logic [1:0]  ls;
    logic [1:0]  hs;
    logic        toggle = 1'h0;
    int          num_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          n;
    always #20 clk_sys = ~clk_sys;
    lfwt_top #(.DIV(TK)) uut (.clk_sys, .reset_n, .rx_in, .chan_sig, .cs_n, .chan_en, .filter_en,
        .high_time_select, .low_time_select, .demod_data_out, .alert_n,
        .noise_timeout_flag, .wake_chan, .soft_reset, .standby, .osc_run);
    lfwt_mcu_model mcu (.clk_sys, .alert_n, .cs_n, .chan_en, .filter_en,
        .high_time_select, .low_time_select);
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // minimum header low time in ticks
    function automatic int low_min(input logic [1:0] s);
        return (s == 2'h3) ? 128 : (s == 2'h2) ? 64 : 32;
    endfunction
    // minimum header high time in ticks
    function automatic int high_min(input logic [1:0] s);
        return (s == 2'h0) ? 32 : (s == 2'h1) ? 64 : 128;
    endfunction
    // awaited event: 0 wake bits, 1 soft reset, 2 alert
    function automatic logic probe(input int sel);
        return (sel == 0) ? |wake_chan : (sel == 1) ? soft_reset : !alert_n;
    endfunction
    // wait for an event, toggling the input every 300 ticks if asked
    task automatic wait_on(input int sel, input int lim);
        n = 0;
        while (probe(sel) !== 1'h1 && n < lim) begin
            @(posedge clk_sys);
            n++;
            if (toggle && n % (300 * TK) == 0) begin
                rx_in <= ~rx_in;
            end
        end
    endtask
    task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %0t: %s", $time, what);
        end
    endtask
    task automatic ticks(input int t);
        repeat (t * TK) @(posedge clk_sys);
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'h1;
        @(posedge clk_sys);
        #1;
        check({standby, osc_run, alert_n}, 9'h005, "reset levels");
        check({demod_data_out, noise_timeout_flag, soft_reset, wake_chan}, 9'h0, "reset");
        lfsr = step(lfsr);
        en = lfsr[2:0] | 3'h1;
        sg = lfsr[6:4] | 3'h1;
        hs = lfsr[8:7];
        ls = lfsr[10:9];
        mcu.cfg_write(en, hs, ls);
        @(posedge clk_sys);
        rx_in    <= 1'h1;
        chan_sig <= sg;
        wait_on(0, 200 * TK);
        #1;
        check(9'(n >= 114 * TK && n <= 117 * TK), 9'h1, "settle time");
        check({6'h0, wake_chan}, {6'h0, en & sg}, "wake bits");
        check({standby, demod_data_out}, 9'h0, "blocked after settle");
        mcu.cfg_write(en, hs, ls);
        rx_in <= 1'h0;
        ticks(4);
        rx_in <= 1'h1;
        ticks(high_min(hs) + 3);
        rx_in <= 1'h0;
        #1;
        check(demod_data_out, 9'h0, "data leak");
        ticks(low_min(ls) + 3);
        rx_in <= 1'h1;
        ticks(1);
        for (int i = 0; i < 16; i++) begin
            lfsr = step(lfsr);
            @(posedge clk_sys);
            rx_in <= lfsr[0];
            @(posedge clk_sys);
            #1;
            check(demod_data_out, {8'h0, lfsr[0]}, "data out");
        end
        wait_on(1, 600 * TK);
        #1;
        check(9'(n >= 510 * TK && n <= 514 * TK), 9'h1, "idle timeout");
        check({standby, osc_run, demod_data_out}, 9'h4, "standby after idle");
        @(posedge clk_sys);
        rx_in <= 1'h1;
        ticks(50);
        rx_in <= 1'h0;
        wait_on(1, 200 * TK);
        #1;
        check(9'(n >= 64 * TK && n <= 67 * TK), 9'h1, "settle abort time");
        check({5'h0, standby, wake_chan}, {5'h1, en & sg}, "settle abort");
        @(posedge clk_sys);
        rx_in  <= 1'h1;
        toggle = 1'h1;
        wait_on(2, 1300 * TK);
        toggle = 1'h0;
        #1;
        check(9'(n >= 1137 * TK && n <= 1141 * TK), 9'h1, "noise time");
        check({alert_n, noise_timeout_flag}, 9'h1, "alert");
        repeat (2) @(posedge clk_sys);
        #1;
        check({6'h0, chan_en}, 9'h0, "back off");
        mcu.cfg_write(en, hs, ls);
        @(posedge clk_sys);
        #1;
        check({alert_n, noise_timeout_flag}, 9'h2, "alert clear");
        check({alert_n, noise_timeout_flag, standby, osc_run}, 9'h9, "final");
        close_out();
    end
endmodule
`default_nettype wire
